// ---- design/two_wire_pkg.sv ----
package two_wire_pkg;

   // Slave address base; the strap code fills the two low bits
   localparam logic [6:0] ADDR_BASE   = 7'h48;
   localparam int         ADDR_SEL_W  = 2;

   // Deglitch filter: samples a line must hold before it is believed
   localparam int         FILTER_LEN  = 3;

   // Clock-low timeout, as a time and as whole cycles (rounded down)
   localparam int         CLK_HZ      = 100_000_000;
   localparam int         TIMEOUT_MS  = 30;
   localparam int         TIMEOUT_CYC = CLK_HZ / 1000 * TIMEOUT_MS;

   // Register word, pointer and commit word layout {msbOnly, ptr, data}
   localparam int         REG_W       = 16;
   localparam int         PTR_W       = 8;
   localparam int         CMT_DATA_LO = 0;
   localparam int         CMT_PTR_LO  = REG_W;
   localparam int         CMT_MSB_POS = REG_W + PTR_W;
   localparam int         CMT_W       = REG_W + PTR_W + 1;
   localparam int         FIFO_DEPTH  = 16;

   // Bit counter marks
   localparam logic [3:0] BIT_LAST_TX = 4'h7;
   localparam logic [3:0] BIT_FULL_RX = 4'h8;

   // Framing states
   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0000,
      ST_ADDR   = 4'b0001,
      ST_AACK   = 4'b0010,
      ST_PTR    = 4'b0011,
      ST_PACK   = 4'b0100,
      ST_WDATA  = 4'b0101,
      ST_WACK   = 4'b0110,
      ST_RDATA  = 4'b0111,
      ST_RACK   = 4'b1000,
      ST_IGNORE = 4'b1001
   } state_type;

endpackage

// ---- design/commit_fifo.sv ----
module commit_fifo #(
   parameter int WIDTH = 25,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Filling side
   input  wire logic             inValid,
   output      logic             inReady,
   input  wire logic [WIDTH-1:0] inData,
   // Draining side
   output      logic             outValid,
   input  wire logic             outReady,
   output      logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];   // Storage words
   logic [AW-1:0]    wrPtr_q;       // Next slot to fill
   logic [AW-1:0]    rdPtr_q;       // Next slot to drain
   logic [AW:0]      count_q;       // Words held in storage
   logic             outValid_q;    // Output register holds a word
   logic [WIDTH-1:0] outData_q;     // Registered read data
   wire              push;
   wire              load;

   // Storage full stalls the framer, which then refuses data bytes;
   // the output register counts too, so DEPTH words in all
   assign inReady  = (count_q + (AW + 1)'(outValid_q)) != (AW + 1)'(DEPTH);
   assign push     = inValid & inReady;
   // Refill the output register when empty or being drained
   assign load     = (~outValid_q | outReady) & (count_q != '0);
   assign outValid = outValid_q;
   assign outData  = outData_q;

   // Memory write, no reset needed on data
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr_q] <= inData;
      end
   end

   // Pointers, occupancy and output stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_q    <= '0;
         rdPtr_q    <= '0;
         count_q    <= '0;
         outValid_q <= 1'b0;
         outData_q  <= '0;
      end else begin
         if (push) begin
            wrPtr_q <= wrPtr_q + 1'b1;
         end
         if (load) begin
            rdPtr_q   <= rdPtr_q + 1'b1;
            outData_q <= mem[rdPtr_q];
         end
         count_q    <= count_q + (AW + 1)'(push) - (AW + 1)'(load);
         outValid_q <= load | (outValid_q & ~outReady);
      end
   end
endmodule

// ---- design/two_wire_slave.sv ----
// Behaviour
// RULE1: Idle bus: both lines high, never pulled.
// RULE2: SDA falling, SCL high: start, take address.
// RULE3: SDA rising, SCL high: stop, back to idle.
// RULE4: Repeated start or stop end transfers; readdress.
// RULE5: Byte count unbounded; keep going until terminated. Writes stop with a refused byte once commit storage is full.
// RULE6: Early termination commits most significant byte only.
// RULE7: Receiver acknowledges in the ninth clock slot.
// RULE8: Acknowledge low before rise, held through high.
// RULE9: Master not-acknowledge ends read; stop driving.
// RULE10: Answer one of four strap-selected addresses.
// RULE11: First write byte sets the register pointer.
// RULE12: Words travel most significant byte first.
// RULE13: Clock low about 30ms resets the interface.
// RULE14: Synchronise and deglitch both lines before use.
module two_wire_slave #(
   parameter int TIMEOUT_CYCLES = two_wire_pkg::TIMEOUT_CYC,
   parameter int FIFO_DEPTH     = two_wire_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic                           clk,
   input  wire logic                           rst_n,
   // Bus pins, SDA open drain
   input  wire logic                           sclIn,
   input  wire logic                           sdaIn,
   output      logic                           sdaOut,
   output      logic                           sdaOe,
   // Address strap: 0 ground, 1 supply, 2 data line, 3 clock line
   input  wire logic [1:0]                     addressSelect,
   // Read side of the register file
   output      logic [two_wire_pkg::PTR_W-1:0] regPtr,
   input  wire logic [two_wire_pkg::REG_W-1:0] rdData,
   // Write commits towards the register file
   output      logic                           cmtValid,
   input  wire logic                           cmtReady,
   output      logic                           cmtMsbOnly,
   output      logic [two_wire_pkg::PTR_W-1:0] cmtPtr,
   output      logic [two_wire_pkg::REG_W-1:0] cmtData
);
   localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
   localparam int FW = $clog2(two_wire_pkg::FILTER_LEN + 1);

   two_wire_pkg::state_type state_q;  // Framing state
   logic [1:0]  syncA_q;       // First sync stage {scl, sda}
   logic [1:0]  syncB_q;       // Second sync stage
   logic [1:0]  clean_q;       // Deglitched lines
   logic [1:0]  prev_q;        // Deglitched lines, one cycle old
   logic [FW-1:0] filt_q [2];  // Disagreement run lengths
   logic [1:0]  strapA_q;      // Strap sync stages
   logic [1:0]  strapB_q;
   logic [6:0]  myAddr_q;      // Own address, from the strap
   logic [3:0]  bitCnt_q;      // Bits moved in this byte
   logic [7:0]  rxSh_q;        // Receive shifter
   logic [7:0]  txSh_q;        // Transmit shifter
   logic [7:0]  txLo_q;        // Low byte kept with its high byte
   logic [7:0]  hiByte_q;      // First data byte of a word
   logic        byteSel_q;     // High byte held / low byte next
   logic        ackOk_q;       // Master acknowledged last byte
   logic        rw_q;          // Direction bit of the address
   logic        sdaOe_q;       // Pulling SDA low
   logic [7:0]  ptr_q;         // Register pointer
   logic        push_q;        // Commit word valid
   logic [two_wire_pkg::CMT_W-1:0] pushData_q;
   logic [TW-1:0] tout_q;      // Clock-low time
   logic        fifoReady;
   logic [two_wire_pkg::CMT_W-1:0] fifoOut;

   // Named decodes of the clean lines
   wire sclHi    = clean_q[1];
   wire sdaHi    = clean_q[0];
   wire sclRise  = clean_q[1] & ~prev_q[1];
   wire sclFall  = ~clean_q[1] & prev_q[1];
   wire bothHigh = clean_q[1] & prev_q[1];
   wire startEv  = bothHigh & prev_q[0] & ~clean_q[0];  // RULE2
   wire stopEv   = bothHigh & ~prev_q[0] & clean_q[0];  // RULE3
   wire toutHit  = tout_q == TW'(TIMEOUT_CYCLES - 1);   // RULE13
   wire byteDone = sclFall & (bitCnt_q == two_wire_pkg::BIT_FULL_RX);
   wire addrHit  = rxSh_q[7:1] == myAddr_q;             // RULE10
   wire inWrite  = (state_q == two_wire_pkg::ST_WDATA)
                 | (state_q == two_wire_pkg::ST_WACK);
   // Receive shifting and counting only while receiving; ack slots must not, transmit counts its bits in ST_RDATA
   wire rxPhase  = (state_q == two_wire_pkg::ST_ADDR)
                 | (state_q == two_wire_pkg::ST_PTR)
                 | (state_q == two_wire_pkg::ST_WDATA);
   wire msbOnly  = (startEv | stopEv) & inWrite & byteSel_q;  // RULE6

   // Two-stage synchronisers for the bus lines and the strap
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         syncA_q  <= 2'h3;
         syncB_q  <= 2'h3;
         strapA_q <= 2'h0;
         strapB_q <= 2'h0;
      end else begin
         syncA_q  <= {sclIn, sdaIn};  // RULE14
         syncB_q  <= syncA_q;
         strapA_q <= addressSelect;
         strapB_q <= strapA_q;
      end
   end

   // Deglitch: a new level must persist before it is accepted
   // One process for both lines keeps clean_q single-driven
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         filt_q[0] <= '0;
         filt_q[1] <= '0;
         clean_q   <= 2'h3;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (syncB_q[i] == clean_q[i]) begin
               filt_q[i] <= '0;
            end else if (filt_q[i] == FW'(two_wire_pkg::FILTER_LEN - 1)) begin
               filt_q[i]  <= '0;
               clean_q[i] <= syncB_q[i];  // RULE14
            end else begin
               filt_q[i] <= filt_q[i] + 1'b1;
            end
         end
      end
   end

   // Edge history and strap capture on every clock after reset release
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_q   <= 2'h3;
         myAddr_q <= two_wire_pkg::ADDR_BASE;
      end else begin
         prev_q   <= clean_q;
         myAddr_q <= two_wire_pkg::ADDR_BASE | {5'h00, strapB_q};
      end
   end

   // Clock-low watchdog, idle bus never times out
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tout_q <= '0;
      end else if (sclHi || state_q == two_wire_pkg::ST_IDLE || toutHit) begin
         tout_q <= '0;
      end else begin
         tout_q <= tout_q + 1'b1;  // RULE13
      end
   end

   // Framing engine; terminations take priority over bit handling
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q    <= two_wire_pkg::ST_IDLE;
         bitCnt_q   <= 4'h0;
         rxSh_q     <= 8'h00;
         txSh_q     <= 8'h00;
         txLo_q     <= 8'h00;
         hiByte_q   <= 8'h00;
         byteSel_q  <= 1'b0;
         ackOk_q    <= 1'b0;
         rw_q       <= 1'b0;
         sdaOe_q    <= 1'b0;
         ptr_q      <= 8'h00;
         push_q     <= 1'b0;
         pushData_q <= '0;
      end else begin
         push_q <= msbOnly;
         if (msbOnly) begin
            // Low byte of the register stays untouched
            pushData_q <= {1'b1, ptr_q, hiByte_q, 8'h00};  // RULE6
         end
         if (toutHit) begin
            state_q <= two_wire_pkg::ST_IDLE;  // RULE13
            sdaOe_q <= 1'b0;
         end else if (startEv) begin
            state_q   <= two_wire_pkg::ST_ADDR;  // RULE2 RULE4
            bitCnt_q  <= 4'h0;
            byteSel_q <= 1'b0;
            sdaOe_q   <= 1'b0;
         end else if (stopEv) begin
            state_q   <= two_wire_pkg::ST_IDLE;  // RULE3 RULE4
            byteSel_q <= 1'b0;
            sdaOe_q   <= 1'b0;  // RULE1
         end else begin
            // Receive shifting, sampled while the clock is high
            if (sclRise && rxPhase && bitCnt_q < two_wire_pkg::BIT_FULL_RX) begin
               rxSh_q   <= {rxSh_q[6:0], sdaHi};
               bitCnt_q <= bitCnt_q + 4'h1;
            end
            unique case (state_q)
               two_wire_pkg::ST_ADDR: begin
                  if (byteDone) begin
                     bitCnt_q <= 4'h0;
                     rw_q     <= rxSh_q[0];
                     sdaOe_q  <= addrHit;  // RULE7
                     state_q  <= addrHit ? two_wire_pkg::ST_AACK
                                         : two_wire_pkg::ST_IGNORE;
                  end
               end
               two_wire_pkg::ST_AACK: begin
                  if (sclFall && rw_q) begin
                     // Whole word taken now so the halves cannot tear
                     txSh_q    <= rdData[15:8];  // RULE12
                     txLo_q    <= rdData[7:0];
                     sdaOe_q   <= ~rdData[15];
                     byteSel_q <= 1'b1;
                     state_q   <= two_wire_pkg::ST_RDATA;
                  end else if (sclFall) begin
                     sdaOe_q <= 1'b0;
                     state_q <= two_wire_pkg::ST_PTR;
                  end
               end
               two_wire_pkg::ST_PTR: begin
                  if (byteDone) begin
                     ptr_q    <= rxSh_q;  // RULE11
                     bitCnt_q <= 4'h0;
                     sdaOe_q  <= 1'b1;    // RULE7
                     state_q  <= two_wire_pkg::ST_PACK;
                  end
               end
               two_wire_pkg::ST_PACK, two_wire_pkg::ST_WACK: begin
                  if (sclFall) begin
                     sdaOe_q <= 1'b0;  // RULE8
                     state_q <= two_wire_pkg::ST_WDATA;  // RULE5
                  end
               end
               two_wire_pkg::ST_WDATA: begin
                  if (byteDone && fifoReady) begin
                     bitCnt_q  <= 4'h0;
                     sdaOe_q   <= 1'b1;  // RULE7
                     state_q   <= two_wire_pkg::ST_WACK;
                     byteSel_q <= ~byteSel_q;  // RULE12
                     hiByte_q  <= rxSh_q;
                     push_q    <= byteSel_q;
                     pushData_q <= {1'b0, ptr_q, hiByte_q, rxSh_q};
                  end else if (byteDone) begin
                     // Storage full: refuse the byte by leaving SDA high
                     state_q <= two_wire_pkg::ST_IGNORE;
                  end
               end
               two_wire_pkg::ST_RDATA: begin
                  if (sclFall && bitCnt_q == two_wire_pkg::BIT_LAST_TX) begin
                     bitCnt_q <= 4'h0;
                     sdaOe_q  <= 1'b0;
                     state_q  <= two_wire_pkg::ST_RACK;
                  end else if (sclFall) begin
                     bitCnt_q <= bitCnt_q + 4'h1;
                     txSh_q   <= {txSh_q[6:0], 1'b0};
                     sdaOe_q  <= ~txSh_q[6];
                  end
               end
               two_wire_pkg::ST_RACK: begin
                  if (sclRise) begin
                     ackOk_q <= ~sdaHi;
                     if (sdaHi) begin
                        state_q <= two_wire_pkg::ST_IGNORE;  // RULE9
                     end
                  end else if (sclFall && ackOk_q) begin
                     txSh_q    <= byteSel_q ? txLo_q : rdData[15:8];
                     sdaOe_q   <= byteSel_q ? ~txLo_q[7] : ~rdData[15];
                     txLo_q    <= byteSel_q ? txLo_q : rdData[7:0];
                     byteSel_q <= ~byteSel_q;
                     bitCnt_q  <= 4'h0;
                     state_q   <= two_wire_pkg::ST_RDATA;  // RULE5
                  end
               end
               two_wire_pkg::ST_IDLE, two_wire_pkg::ST_IGNORE: begin
                  sdaOe_q <= 1'b0;  // RULE1 RULE9
               end
               default: begin
                  state_q <= two_wire_pkg::ST_IDLE;
                  sdaOe_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // Commit words queue here until the register file takes them
   commit_fifo #(
      .WIDTH (two_wire_pkg::CMT_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk      (clk),
      .rst_n    (rst_n),
      .inValid  (push_q),
      .inReady  (fifoReady),
      .inData   (pushData_q),
      .outValid (cmtValid),
      .outReady (cmtReady),
      .outData  (fifoOut)
   );

   // Open drain: the data value is always low, only the enable moves
   assign sdaOut     = 1'b0;
   assign sdaOe      = sdaOe_q;
   assign regPtr     = ptr_q;
   assign cmtMsbOnly = fifoOut[two_wire_pkg::CMT_MSB_POS];
   assign cmtPtr     = fifoOut[two_wire_pkg::CMT_PTR_LO +: 8];
   assign cmtData    = fifoOut[two_wire_pkg::CMT_DATA_LO +: 16];

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_rxByteEnd;
      byteDone && !startEv && !stopEv && !toutHit;
   endsequence
   sequence s_quiet;
      !startEv && !stopEv && !toutHit;
   endsequence

   a_idle_released: assert property ( // RULE1
      state_q == two_wire_pkg::ST_IDLE |=> !sdaOe_q || startEv)
      else $error("SDA pulled while idle");
   a_start_address: assert property ( // RULE2
      startEv && !toutHit |=> state_q == two_wire_pkg::ST_ADDR
                              && bitCnt_q == 4'h0 && !sdaOe_q)
      else $error("Start did not open address phase");
   a_stop_idle: assert property ( // RULE3
      stopEv && !startEv && !toutHit
      |=> state_q == two_wire_pkg::ST_IDLE && !sdaOe_q)
      else $error("Stop did not return to idle");
   a_write_goes_on: assert property ( // RULE5
      state_q == two_wire_pkg::ST_WACK && sclFall and s_quiet
      |=> state_q == two_wire_pkg::ST_WDATA)
      else $error("Write stream ended early");
   a_msb_commit: assert property ( // RULE6
      msbOnly && !toutHit |=> push_q && pushData_q[24]
                            && pushData_q[7:0] == 8'h00)
      else $error("Short write not committed as high byte");
   a_addr_ack: assert property ( // RULE7
      state_q == two_wire_pkg::ST_ADDR and s_rxByteEnd
      |=> sdaOe_q == $past(addrHit))
      else $error("Address acknowledge wrong");
   a_ack_held: assert property ( // RULE8
      state_q == two_wire_pkg::ST_WACK && sdaOe_q && sclRise and s_quiet
      |=> sdaOe_q [*2])
      else $error("Acknowledge released during clock high");
   a_nack_release: assert property ( // RULE9
      state_q == two_wire_pkg::ST_RACK && sclRise && sdaHi and s_quiet
      |=> state_q == two_wire_pkg::ST_IGNORE ##1 !sdaOe_q)
      else $error("Data still driven after not-acknowledge");
   a_ptr_store: assert property ( // RULE11
      state_q == two_wire_pkg::ST_PTR and s_rxByteEnd
      |=> ptr_q == $past(rxSh_q))
      else $error("Pointer not stored");
   a_msb_first: assert property ( // RULE12
      state_q == two_wire_pkg::ST_AACK && sclFall && rw_q and s_quiet
      |=> txSh_q == $past(rdData[15:8]) && txLo_q == $past(rdData[7:0]))
      else $error("Read word not high byte first");
   a_timeout_reset: assert property ( // RULE13
      toutHit |=> state_q == two_wire_pkg::ST_IDLE && !sdaOe_q
                 && tout_q == '0)
      else $error("Timeout did not reset interface");
endmodule

// ---- tb/two_wire_master_model.sv ----
// Bus master that owns the serial clock; bench calls its tasks
module two_wire_master_model (
   // System clock used as the timing base
   input  wire logic clk,
   // Bus lines, data is open drain with a pull-up
   output      logic scl,
   output      logic sdaDrv,
   input  wire logic sdaLine
);
   timeunit 1ns;
   timeprecision 1ps;

   // Both lines released at power-up: bus idle
   initial begin
      scl = 1'b1;
      sdaDrv = 1'b1;
   end

   task automatic waitCyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Start or repeated start; leaves the clock low
   task automatic start();
      waitCyc(4);
      sdaDrv <= 1'b1;
      waitCyc(4);
      scl <= 1'b1;
      waitCyc(8);
      sdaDrv <= 1'b0;
      waitCyc(8);
      scl <= 1'b0;
   endtask

   // Stop: data rises while the clock is high
   task automatic stop();
      waitCyc(4);
      sdaDrv <= 1'b0;
      waitCyc(4);
      scl <= 1'b1;
      waitCyc(8);
      sdaDrv <= 1'b1;
      waitCyc(8);
   endtask

   // One clock slot of 160 ns; data moves mid-low, sampled twice high
   task automatic clockBit(input logic b, input logic spike,
                           output logic s0, output logic s1);
      waitCyc(4);
      sdaDrv <= b;
      waitCyc(4);
      scl <= 1'b1;
      waitCyc(2);
      #1 s0 = sdaLine;
      // A one-cycle spike must be filtered, not taken as start/stop
      if (spike) begin
         sdaDrv <= ~b;
         waitCyc(1);
         sdaDrv <= b;
         waitCyc(4);
      end else begin
         waitCyc(5);
      end
      #1 s1 = sdaLine;
      waitCyc(1);
      scl <= 1'b0;
   endtask

   // Byte out, most significant bit first, then the ninth slot
   task automatic writeByte(input logic [7:0] b, input logic spike,
                            output logic ackOk);
      logic s0;
      logic s1;
      for (int i = 7; i >= 0; i--) begin
         clockBit(b[i], spike && (i == 3), s0, s1);
      end
      clockBit(1'b1, 1'b0, s0, s1);
      ackOk = (s0 === 1'b0) && (s1 === 1'b0);
   endtask

   // Byte in, then acknowledge or not-acknowledge
   task automatic readByte(input logic masterAck, output logic [7:0] b);
      logic s0;
      logic s1;
      for (int i = 7; i >= 0; i--) begin
         clockBit(1'b1, 1'b0, s0, s1);
         b[i] = s1;
      end
      clockBit(~masterAck, 1'b0, s0, s1);
   endtask
endmodule

// ---- tb/tb_top.sv ----
`define CHECK(got, exp, msg) begin \
   samples_checked++; \
   if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("wrong value at %0t ns: %s", $time, msg); \
   end \
end

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int TO = 2000; // Short clock-low timeout for simulation

   // Clock, reset and strap
   logic                           clk;
   logic                           rst_n;
   logic [1:0]                     addressSelect;
   // Bus lines
   logic                           scl;
   logic                           sdaDrv;
   logic                           sdaOut;
   logic                           sdaOe;
   wire logic                      sdaLine;
   // Register file side
   logic [two_wire_pkg::PTR_W-1:0] regPtr;
   logic [two_wire_pkg::REG_W-1:0] rdData;
   logic                           cmtValid;
   logic                           cmtReady;
   logic                           cmtMsbOnly;
   logic [two_wire_pkg::PTR_W-1:0] cmtPtr;
   logic [two_wire_pkg::REG_W-1:0] cmtData;
   // Scoreboard
   int                             n_mismatch;
   int                             samples_checked;
   logic [two_wire_pkg::CMT_W-1:0] commits[$];
   logic                           a;

   // Open-drain wire with pull-up
   assign sdaLine = sdaDrv & (sdaOe ? sdaOut : 1'b1);

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Register file stand-in and commit collector
   always @(posedge clk) begin
      rdData <= {regPtr ^ 8'hA5, regPtr};
      if (cmtValid && cmtReady) begin
         commits.push_back({cmtMsbOnly, cmtPtr, cmtData});
      end
   end

   two_wire_slave #(.TIMEOUT_CYCLES(TO), .FIFO_DEPTH(16)) u_two_wire_slave (
      .clk(clk), .rst_n(rst_n), .sclIn(scl), .sdaIn(sdaLine),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .addressSelect(addressSelect),
      .regPtr(regPtr), .rdData(rdData), .cmtValid(cmtValid),
      .cmtReady(cmtReady), .cmtMsbOnly(cmtMsbOnly), .cmtPtr(cmtPtr),
      .cmtData(cmtData));

   two_wire_master_model u_two_wire_master_model (
      .clk(clk), .scl(scl), .sdaDrv(sdaDrv), .sdaLine(sdaLine));

   task automatic conclude();
      $display("checks %0d, mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic waitCyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Strap is resampled every clock, not only at reset release; set here with the reset
   task automatic resetDut(input logic [1:0] code);
      rst_n <= 1'b0;
      addressSelect <= code;
      waitCyc(8);
      rst_n <= 1'b1;
      waitCyc(10);
   endtask

   task automatic addr(input logic [1:0] code, input logic rd,
                       output logic ok);
      u_two_wire_master_model.start();
      u_two_wire_master_model.writeByte(
         {7'(two_wire_pkg::ADDR_BASE + code), rd}, 1'b0, ok);
   endtask

   // Bounded wait for commits to arrive
   task automatic waitCommits(input int n);
      for (int i = 0; i < 300 && commits.size() < n; i++) waitCyc(1);
      if (commits.size() < n) begin
         n_mismatch++;
         $display("wrong value at %0t ns: commit missing", $time);
         conclude();
      end
   endtask

   task automatic t_address();
      for (int c = 0; c < 4; c++) begin
         resetDut(2'(c));
         `CHECK(sdaOe, 1'b0, "idle drive")
         addr(2'(c), 1'b0, a);
         `CHECK(a, 1'b1, "own address")
         u_two_wire_master_model.stop();
         addr(2'(c + 1), 1'b0, a);
         `CHECK(a, 1'b0, "foreign address")
         u_two_wire_master_model.stop();
      end
      $display("test address done");
   endtask

   task automatic t_write_words();
      logic [7:0] wb[4] = '{8'h12, 8'h34, 8'h56, 8'h78};
      commits.delete();
      addr(2'd3, 1'b0, a);
      // Spike inside the pointer byte must not break framing
      u_two_wire_master_model.writeByte(8'h3C, 1'b1, a);
      `CHECK(a, 1'b1, "pointer ack")
      `CHECK(regPtr, 8'h3C, "pointer")
      for (int i = 0; i < 4; i++) begin
         u_two_wire_master_model.writeByte(wb[i], 1'b0, a);
         `CHECK(a, 1'b1, "data ack")
      end
      u_two_wire_master_model.stop();
      waitCommits(2);
      `CHECK(commits[0], {1'b0, 8'h3C, 16'h1234}, "word 0")
      `CHECK(commits[1], {1'b0, 8'h3C, 16'h5678}, "word 1")
      $display("test write words done");
   endtask

   task automatic t_short_read();
      logic [7:0] hi;
      logic [7:0] lo;
      logic [7:0] hi2;
      commits.delete();
      addr(2'd3, 1'b0, a);
      u_two_wire_master_model.writeByte(8'h01, 1'b0, a);
      u_two_wire_master_model.writeByte(8'hAB, 1'b0, a);
      addr(2'd3, 1'b1, a);
      `CHECK(a, 1'b1, "readdress")
      u_two_wire_master_model.readByte(1'b1, hi);
      u_two_wire_master_model.readByte(1'b1, lo);
      u_two_wire_master_model.readByte(1'b0, hi2);
      waitCyc(12);
      `CHECK(sdaOe, 1'b0, "drive after nack")
      u_two_wire_master_model.stop();
      `CHECK({hi, lo}, 16'hA401, "read word")
      `CHECK(hi2, 8'hA4, "next word")
      waitCommits(1);
      `CHECK(commits[0], {1'b1, 8'h01, 16'hAB00}, "msb only")
      $display("test short write and read done");
   endtask

   // Consumer stalls: 16 words fit, the next byte is refused
   task automatic t_fifo_full();
      commits.delete();
      cmtReady <= 1'b0;
      addr(2'd3, 1'b0, a);
      u_two_wire_master_model.writeByte(8'h02, 1'b0, a);
      for (int i = 0; i < 32; i++) begin
         u_two_wire_master_model.writeByte(8'(i), 1'b0, a);
         `CHECK(a, 1'b1, "fill ack")
      end
      u_two_wire_master_model.writeByte(8'hEE, 1'b0, a);
      `CHECK(a, 1'b0, "full refusal")
      u_two_wire_master_model.stop();
      cmtReady <= 1'b1;
      waitCommits(16);
      waitCyc(5);
      `CHECK(commits.size(), 16, "drain count")
      for (int i = 0; i < 16; i++) begin
         `CHECK(commits[i], {1'b0, 8'h02, 8'(2 * i), 8'(2 * i + 1)}, "drain")
      end
      $display("test fifo full done");
   endtask

   // Clock held low during the ack slot until the interface gives up
   task automatic t_timeout();
      logic [7:0] adr;
      logic       s0;
      logic       s1;
      adr = {7'(two_wire_pkg::ADDR_BASE + 7'd3), 1'b0};
      u_two_wire_master_model.start();
      for (int i = 7; i >= 0; i--) begin
         u_two_wire_master_model.clockBit(adr[i], 1'b0, s0, s1);
      end
      waitCyc(20);
      `CHECK(sdaOe, 1'b1, "ack drive")
      waitCyc(TO + 50);
      `CHECK(sdaOe, 1'b0, "timeout release")
      u_two_wire_master_model.stop();
      addr(2'd3, 1'b0, a);
      `CHECK(a, 1'b1, "after timeout")
      u_two_wire_master_model.stop();
      $display("test timeout done");
   endtask

   initial begin
      rst_n = 1'b0;
      addressSelect = 2'h0;
      cmtReady = 1'b1;
      n_mismatch = 0;
      samples_checked = 0;
      t_address();
      t_write_words();
      t_short_read();
      t_fifo_full();
      t_timeout();
      conclude();
   end
endmodule
